// ### hw/shp_pkg.sv
`default_nettype none

// ****************************************************************
// Segment header packer shared definitions.
// ****************************************************************
package shp_pkg;

    // Field widths of the segment header, in header order.
    localparam int SRC_PORT_W = 16;
    localparam int DST_PORT_W = 16;
    localparam int SEG_TYPE_W = 3;
    localparam int HDR_LEN_W = 12;
    localparam int FLAG_W = 1;
    localparam int SERIAL_W = 16;
    localparam int SEG_NUM_W = 16;
    localparam int LAST_SEG_W = 16;

    // Header size in octets and in bits.
    localparam int HDR_OCTETS = 12;
    localparam int HDR_BITS = HDR_OCTETS * 8;

    // Index of the last header octet.
    localparam logic [3:0] LAST_HDR_IDX = 4'hB;

    // Index of the last bit within an octet.
    localparam logic [2:0] LAST_BIT_IDX = 3'h7;

    // Field values for one header, supplied by the upper layer.
    typedef struct packed {
        logic [SRC_PORT_W-1:0] src_port;
        logic [DST_PORT_W-1:0] dst_port;
        logic [SEG_TYPE_W-1:0] seg_type;
        logic [HDR_LEN_W-1:0] header_length_field;
        logic [FLAG_W-1:0] flag;
        logic [SERIAL_W-1:0] serial_num;
        logic [SEG_NUM_W-1:0] seg_num;
        logic [LAST_SEG_W-1:0] last_seg_num;
    } shp_fields_type;

    // One octet of the data portion with its end marker.
    typedef struct packed {
        logic [7:0] octet;
        logic last;
    } shp_data_type;

    // Packer states.
    typedef enum logic [1:0] {
        SHP_IDLE = 2'b00,
        SHP_HDR = 2'b01,
        SHP_DATA = 2'b10
    } shp_state_type;

endpackage : shp_pkg

`default_nettype wire

// ### hw/shp_packer.sv
`default_nettype none

// ****************************************************************
// Segment header packer.
// ****************************************************************
// Takes the field values of one segment header, packs them into a
// twelve-octet header and then forwards the data portion. Each octet
// leaves twice: as a parallel octet, numbered if a header octet, and as a serial
// bit stream, least significant bit first, one bit per cycle.
// A new octet is only loaded when the serialiser is free, so the
// parallel and serial views always match and the source is stalled
// by its ready signals.

// Operation
// (RULE_01) Field MSB goes to highest free bit.
// (RULE_02) Overflowing field bits continue into next octet.
// (RULE_03) Fields packed in order, no gaps.
// (RULE_04) Octets numbered consecutively from zero.
// (RULE_05) Header is exactly twelve octets, 0 to 11.
// (RULE_06) Segment number directly precedes last segment number.
// (RULE_07) Header octets passed on in ascending order.
// (RULE_08) Serial line sends bit 2^0 first.
// (RULE_09) Type 3, length 12, flag 1 bit.
// (RULE_10) Data portion follows header unchanged, in order.
module shp_packer
    import shp_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Header field request from the upper layer.
    input wire logic hdr_valid,
    input wire shp_fields_type hdr_fields,
    output logic hdr_ready,
    // Data portion from the upper layer.
    input wire logic data_valid,
    input wire shp_data_type data_in,
    output logic data_ready,
    // Parallel octet stream to the lower layer.
    output logic oct_valid,
    output logic [7:0] oct_data,
    output logic [3:0] oct_num,
    output logic oct_is_hdr,
    output logic oct_last,
    // Serial line to the lower layer.
    output logic ser_bit,
    output logic ser_valid,
    output logic ser_first
);

    // ****************************************************************
    // State.
    // ****************************************************************

    // Packer state.
    shp_state_type state_q;
    // Packed header, first octet in the top bits.
    logic [HDR_BITS-1:0] hdr_q;
    // Number of the next header octet to load.
    logic [3:0] idx_q;
    // Octet being shifted out on the serial line.
    logic [7:0] shift_q;
    // Bit counter of the serial line.
    logic [2:0] bit_q;
    // Serialiser busy with an octet.
    logic busy_q;
    // Serialiser can take an octet this cycle.
    logic ser_free;
    // A header octet or a data octet is loaded this cycle.
    logic load_hdr;
    logic load_data;
    // Packed image of the fresh fields.
    logic [HDR_BITS-1:0] packed_fields;

    // Concatenation packs every field MSB first from the top with no
    // gap; octet n is bits [HDR_BITS-1-8n -: 8], so fields that
    // straddle octets continue at the next octet's MSB.
    // [RULE_01] [RULE_02] [RULE_03] [RULE_06] [RULE_09]
    assign packed_fields = {hdr_fields.src_port, hdr_fields.dst_port,
                            hdr_fields.seg_type, hdr_fields.header_length_field,
                            hdr_fields.flag, hdr_fields.serial_num,
                            hdr_fields.seg_num, hdr_fields.last_seg_num};

    // The serialiser is free when idle or on its last bit.
    assign ser_free = !busy_q || (bit_q == LAST_BIT_IDX);
    assign load_hdr = (state_q == SHP_HDR) && ser_free;
    // A data octet is only taken when the upper layer saw data_ready, so
    // the handshake and the load always agree.
    assign load_data = (state_q == SHP_DATA) && ser_free && data_valid && data_ready;

    // Ready terms are registered so outputs come from flip-flops.
    // They anticipate the next cycle's free slot.

    // ****************************************************************
    // Sequencing.
    // ****************************************************************

    // Walks idle, header and data phases and captures the fields.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= SHP_IDLE;
            hdr_q <= '0;
            idx_q <= 4'h0;
        end else begin
            unique case (state_q)
                // Accept fields once the previous segment has drained.
                SHP_IDLE: begin
                    if (hdr_valid && hdr_ready) begin
                        hdr_q <= packed_fields;
                        idx_q <= 4'h0; // [RULE_04]
                        state_q <= SHP_HDR;
                    end
                end
                // Load octets 0 to 11 in ascending order.
                SHP_HDR: begin
                    if (load_hdr) begin
                        hdr_q <= {hdr_q[HDR_BITS-9:0], 8'h00}; // [RULE_07]
                        idx_q <= idx_q + 4'h1; // [RULE_04]
                        if (idx_q == LAST_HDR_IDX) begin
                            state_q <= SHP_DATA; // [RULE_05]
                        end
                    end
                end
                // Forward data octets until the marked last one.
                SHP_DATA: begin
                    if (load_data && data_in.last) begin
                        state_q <= SHP_IDLE; // [RULE_10]
                    end
                end
                default: begin
                    state_q <= SHP_IDLE;
                end
            endcase
        end
    end

    // Registered ready signals toward the upper layer.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hdr_ready <= 1'b0;
            data_ready <= 1'b0;
        end else begin
            // Fields are taken only in idle, once, and with the line quiet, so
            // octet 0 always leaves two cycles after the fields are taken.
            hdr_ready <= (state_q == SHP_IDLE) && !busy_q && !(hdr_valid && hdr_ready);
            // Data ready promises a free serialiser in the next cycle; it drops
            // after each taken octet so one slot never takes two octets.
            data_ready <= 1'b0;
            if (state_q == SHP_DATA && !load_data) begin
                data_ready <= !busy_q || (bit_q >= LAST_BIT_IDX - 3'h1);
            end
            if (state_q == SHP_HDR && load_hdr && idx_q == LAST_HDR_IDX) begin
                data_ready <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Parallel octet output.
    // ****************************************************************

    // Presents each loaded octet for one cycle; header octets carry their number, data octets 0.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            oct_valid <= 1'b0;
            oct_data <= 8'h00;
            oct_num <= 4'h0;
            oct_is_hdr <= 1'b0;
            oct_last <= 1'b0;
        end else begin
            oct_valid <= load_hdr || (load_data && data_ready);
            oct_last <= 1'b0;
            if (load_hdr) begin
                oct_data <= hdr_q[HDR_BITS-1 -: 8]; // [RULE_07]
                oct_num <= idx_q; // [RULE_04]
                oct_is_hdr <= 1'b1;
            end else if (load_data && data_ready) begin
                oct_data <= data_in.octet; // [RULE_10]
                oct_num <= 4'h0;
                oct_is_hdr <= 1'b0;
                oct_last <= data_in.last;
            end
        end
    end

    // ****************************************************************
    // Serial line.
    // ****************************************************************

    // Shifts each octet out least significant bit first.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            shift_q <= 8'h00;
            bit_q <= 3'h0;
            busy_q <= 1'b0;
            ser_bit <= 1'b0;
            ser_valid <= 1'b0;
            ser_first <= 1'b0;
        end else if (load_hdr || (load_data && data_ready)) begin
            // Bit 2^0 leaves now, the rest wait in the shifter.
            if (load_hdr) begin
                ser_bit <= hdr_q[HDR_BITS-8]; // [RULE_08]
                shift_q <= {1'b0, hdr_q[HDR_BITS-1 -: 7]};
            end else begin
                ser_bit <= data_in.octet[0]; // [RULE_08]
                shift_q <= {1'b0, data_in.octet[7:1]};
            end
            ser_first <= load_hdr && (idx_q == 4'h0);
            ser_valid <= 1'b1;
            busy_q <= 1'b1;
            bit_q <= 3'h0;
        end else if (busy_q && bit_q != LAST_BIT_IDX) begin
            // Next bit towards 2^7.
            ser_bit <= shift_q[0]; // [RULE_08]
            shift_q <= {1'b0, shift_q[7:1]};
            bit_q <= bit_q + 3'h1;
            ser_first <= 1'b0;
        end else begin
            // Line idle after the octet's last bit.
            busy_q <= 1'b0;
            ser_valid <= 1'b0;
            ser_first <= 1'b0;
            ser_bit <= 1'b0;
            bit_q <= 3'h0;
        end
    end

endmodule : shp_packer

`default_nettype wire

// ### dv/shp_packer_asserts.sv
`default_nettype none

// Watches the packer ports and ties each output except data_ready to its cause.
module shp_packer_asserts
    import shp_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Upper layer handshakes.
    input wire logic hdr_valid,
    input wire logic hdr_ready,
    input wire logic data_valid,
    input wire logic data_ready,
    input wire shp_fields_type hdr_fields,
    input wire shp_data_type data_in,
    // Octet and serial outputs.
    input wire logic oct_valid,
    input wire logic oct_is_hdr,
    input wire logic oct_last,
    input wire logic ser_bit,
    input wire logic ser_valid,
    input wire logic ser_first,
    input wire logic [7:0] oct_data,
    input wire logic [3:0] oct_num
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_first; hdr_valid && hdr_ready |-> ##2 oct_valid && ser_first && oct_num == 4'h0;
    endproperty
    a_first: assert property (p_first) else $error("first octet late");
    property p_msb; hdr_valid && hdr_ready |-> ##2 oct_data == $past(hdr_fields[95:88], 2)
        ##8 oct_data == $past(hdr_fields[87:80], 10); endproperty
    a_msb: assert property (p_msb) else $error("source port split wrong");
    property p_tail; hdr_valid && hdr_ready |-> ##66 oct_data == $past(hdr_fields[31:24], 66)
        ##24 oct_data == $past(hdr_fields[7:0], 90); endproperty
    a_tail: assert property (p_tail) else $error("final word misplaced");
    property p_step; oct_valid && oct_is_hdr && oct_num != 4'hB |-> ##8 oct_valid && oct_is_hdr
        && oct_num == $past(oct_num, 8) + 4'h1; endproperty
    a_step: assert property (p_step) else $error("octet number not next");
    property p_len; oct_valid && oct_is_hdr && oct_num == 4'hB |=> !oct_valid [*7]
        ##1 !(oct_valid && oct_is_hdr); endproperty
    a_len: assert property (p_len) else $error("header longer than twelve");
    property p_bits; oct_valid |-> ser_valid && ser_bit == oct_data[0]
        ##7 ser_valid && ser_bit == $past(oct_data[7], 7); endproperty
    a_bits: assert property (p_bits) else $error("serial bit order wrong");
    property p_data; data_valid && data_ready |=> oct_valid && !oct_is_hdr
        && oct_data == $past(data_in.octet) && oct_last == $past(data_in.last); endproperty
    a_data: assert property (p_data) else $error("data octet altered");
    property p_busy; hdr_valid && hdr_ready |=> !hdr_ready [*8]; endproperty
    a_busy: assert property (p_busy) else $error("fields taken mid segment");
endmodule : shp_packer_asserts

bind shp_packer shp_packer_asserts shp_packer_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .data_valid(data_valid),
    .data_ready(data_ready), .hdr_fields(hdr_fields), .data_in(data_in), .oct_valid(oct_valid),
    .oct_is_hdr(oct_is_hdr), .oct_last(oct_last), .ser_bit(ser_bit), .ser_valid(ser_valid),
    .ser_first(ser_first), .oct_data(oct_data), .oct_num(oct_num));

`default_nettype wire

// ### dv/shp_lower_model.sv
`default_nettype none

// Lower serial layer: rebuilds octets from the line, first bit is 2^0.
module shp_lower_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ser_bit,
    input wire logic ser_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh_q;
    logic [2:0] cnt_q;
    logic [7:0] got[$];
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_q <= 3'h0;
        end else if (ser_valid) begin
            sh_q <= {ser_bit, sh_q[7:1]};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
                got.push_back({ser_bit, sh_q[7:1]});
            end
        end
    end
endmodule : shp_lower_model

`default_nettype wire

// ### dv/tb_segment_header_packer.sv
`default_nettype none

module tb_segment_header_packer
    import shp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("unexpected %0t octet mismatch", $time); end end
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hdr_valid = 1'b0;
    shp_fields_type hdr_fields = '0;
    logic data_valid = 1'b0;
    shp_data_type data_in = '0;
    logic hdr_ready, data_ready, oct_valid, oct_is_hdr, oct_last, ser_bit, ser_valid, ser_first;
    logic [7:0] oct_data;
    logic [3:0] oct_num;
    int error_cnt = 0;
    int n_compared = 0;
    logic [13:0] cap[$];
    logic [7:0] d1 [4] = '{8'hA5, 8'h00, 8'h00, 8'h00};
    logic [7:0] d2 [4] = '{8'h80, 8'h01, 8'hFF, 8'h00};
    always #2 clk_sys = ~clk_sys;
    // Parallel octets as {is_hdr, last, num, data}.
    always @(posedge clk_sys) begin
        if (oct_valid) begin
            cap.push_back({oct_is_hdr, oct_last, oct_num, oct_data});
        end
    end
    shp_packer shp_packer_i (.clk_sys(clk_sys), .rst_n(rst_n), .hdr_valid(hdr_valid),
        .hdr_fields(hdr_fields), .hdr_ready(hdr_ready), .data_valid(data_valid),
        .data_in(data_in), .data_ready(data_ready), .oct_valid(oct_valid), .oct_data(oct_data),
        .oct_num(oct_num), .oct_is_hdr(oct_is_hdr), .oct_last(oct_last), .ser_bit(ser_bit),
        .ser_valid(ser_valid), .ser_first(ser_first));
    shp_lower_model shp_lower_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .ser_bit(ser_bit),
        .ser_valid(ser_valid));
    task automatic close_out();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    task automatic bound(input logic ok);
        if (!ok) begin
            error_cnt++;
            $display("unexpected %0t wait timed out", $time);
            close_out();
        end
    endtask : bound
    // Offers fields, then n data octets with gap idle cycles before each.
    task automatic feed(input shp_fields_type f, input logic [7:0] d [4], input int n, int gap);
        int k;
        @(negedge clk_sys);
        hdr_fields = f;
        hdr_valid = 1'b1;
        for (k = 0; k < 400; k++) begin
            @(posedge clk_sys);
            if (hdr_ready) break;
        end
        bound(k < 400);
        @(negedge clk_sys);
        hdr_valid = 1'b0;
        for (int j = 0; j < n; j++) begin
            repeat (gap) @(negedge clk_sys);
            data_in = {d[j], j == n - 1};
            data_valid = 1'b1;
            for (k = 0; k < 400; k++) begin
                @(posedge clk_sys);
                if (data_ready) break;
            end
            bound(k < 400);
            @(negedge clk_sys);
            if (gap > 0 || j == n - 1) data_valid = 1'b0;
        end
    endtask : feed
    // Compares one segment from position b of both captured streams.
    task automatic check(input logic [95:0] h, input logic [7:0] d [4], input int n, int b);
        logic [13:0] e;
        for (int i = 0; i < 12 + n; i++) begin
            if (i < 12) e = {2'b10, i[3:0], h[95 - 8 * i -: 8]};
            else e = {1'b0, i == 11 + n, 4'h0, d[i - 12]};
            `CHK(cap[b + i], e)
            `CHK(shp_lower_model_i.got[b + i], e[7:0])
        end
    endtask : check
    task automatic drain(input int t);
        int k;
        for (k = 0; k < 2000; k++) begin
            @(posedge clk_sys);
            if (cap.size() >= t) break;
        end
        bound(k < 2000);
        repeat (12) @(posedge clk_sys);
    endtask : drain
    // Worked example values against their known octets.
    task automatic t_example();
        feed('{16'h1388, 16'h062D, 3'h2, 12'h003, 1'h1, 16'h3E80, 16'h0104, 16'h012C}, d1, 1, 0);
        drain(13);
        check(96'h1388_062D_4007_3E80_0104_012C, d1, 1, 0);
        cap.delete();
        shp_lower_model_i.got.delete();
    endtask : t_example
    // Second header offered while the first is busy; stalled data.
    task automatic t_back_to_back();
        feed('1, d2, 3, 0);
        feed(96'h0123_4567_89AB_CDEF_FEDC_BA98, d1, 2, 3);
        drain(29);
        check('1, d2, 3, 0);
        check(96'h0123_4567_89AB_CDEF_FEDC_BA98, d1, 2, 15);
    endtask : t_back_to_back
    initial begin
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        t_example();
        t_back_to_back();
        close_out();
    end
endmodule : tb_segment_header_packer

`default_nettype wire
